// [verilog/qrb_release_regs.sv]
`include "qrb_regs.svh"
module qrb_release_regs
  import qrb_pkg::*;
#(
  parameter int TAG_W = 5
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        release_i,
  input  wire logic [4:0]  release_tag_i,
  input  wire logic        other_ready_i,
  input  wire logic        cmd_prepared_i,
  input  wire logic        service_cmd_i,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             service_pending_o,
  output logic             service_taken_o
);

  initial begin
    if (TAG_W != 5) $error("qrb_release_regs: tag field is five bits wide");
  end

  qrb_state_t  state;
  qrb_pair_t   count_tag;
  qrb_pair_t   addr_low;
  qrb_pair_t   addr_mid;
  qrb_pair_t   addr_high;
  qrb_pair_t   features;
  logic        sector_full;
  logic [7:0]  device_select;
  logic [7:0]  device_status;
  logic [7:0]  error_flags;
  logic [7:0]  control;
  logic [`QRB_EVT_COUNT-1:0] events;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_off;
  logic [7:0]  w_byte;
  logic        w_lane0;
  logic        wr_fire;
  logic        high_order_select;
  logic        tag_valid;
  logic [7:0]  next_tag_byte;
  logic [7:0]  rd_byte;
  logic        rd_hit;

  function automatic logic reg_mapped(input logic [7:0] off);
    case (off)
      `QRB_OFF_ERROR, `QRB_OFF_COUNT, `QRB_OFF_ADDR_LO, `QRB_OFF_ADDR_MID,
      `QRB_OFF_ADDR_HI, `QRB_OFF_DEVSEL, `QRB_OFF_STATUS,
      `QRB_OFF_CONTROL, `QRB_OFF_EVENT, `QRB_OFF_FEATURES,
      `QRB_OFF_SECT_FULL: reg_mapped = 1'b1;
      default: reg_mapped = 1'b0;
    endcase
  endfunction : reg_mapped

  assign high_order_select = control[`QRB_CTL_HOB];
  assign tag_valid = control[`QRB_CTL_QUEUE] & control[`QRB_CTL_OVL];
  assign next_tag_byte = {(tag_valid ? release_tag_i : 5'h00), 1'b1, 1'b1, 1'b0};
  assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
  // zero features pair
  // An all-zero pair asks for the full 65,536 sectors, not for none
  assign sector_full = (features == '0);

  // Write address and data are taken in either order, response follows both
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_off        <= 8'h00;
      w_byte        <= 8'h00;
      w_lane0       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `QRB_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_off  <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= reg_mapped(aw_off) ? `QRB_RESP_OKAY : `QRB_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Command sequence: release, service request, service command
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= QRB_IDLE;
    end else begin
      case (state)
        QRB_IDLE:          if (release_i) state <= QRB_RELEASED;
        QRB_RELEASED:      if (cmd_prepared_i) state <= QRB_SERVICE_READY;
        QRB_SERVICE_READY: if (service_cmd_i) state <= QRB_SERVICING;
        QRB_SERVICING:     state <= QRB_IDLE;
        default:           state <= QRB_IDLE;
      endcase
    end
  end

  // Shadow pairs: a write moves current into previous, as the HIGH_ORDER_SELECT view needs
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_tag <= '0;
      addr_low  <= '0;
      addr_mid  <= '0;
      addr_high <= '0;
      features  <= '0;
    end else if (state == QRB_IDLE && release_i) begin
      count_tag <= '{cur: next_tag_byte, prev: count_tag.cur};
    end else if (wr_fire && w_lane0) begin
      // A lane-0 write to a pair offset pushes current into previous, unless a release in idle lands in the same cycle
      case (aw_off)
        `QRB_OFF_COUNT:    count_tag <= '{cur: w_byte, prev: count_tag.cur};
        `QRB_OFF_ADDR_LO:  addr_low  <= '{cur: w_byte, prev: addr_low.cur};
        `QRB_OFF_ADDR_MID: addr_mid  <= '{cur: w_byte, prev: addr_mid.cur};
        `QRB_OFF_ADDR_HI:  addr_high <= '{cur: w_byte, prev: addr_high.cur};
        `QRB_OFF_FEATURES: features  <= '{cur: w_byte, prev: features.cur};
        default: ;
      endcase
    end
  end

  // Control, device select and error byte
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      control       <= `QRB_CTL_RST;
      device_select <= `QRB_DEVSEL_RST;
      error_flags   <= 8'h00;
    end else begin
      if (wr_fire && w_lane0 && aw_off == `QRB_OFF_CONTROL) control <= w_byte;
      if (wr_fire && w_lane0 && aw_off == `QRB_OFF_DEVSEL) device_select <= w_byte;
      else device_select[`QRB_DEV_BIT] <= control[`QRB_CTL_DEV];
      if (state == QRB_IDLE && release_i) error_flags <= 8'h00;
    end
  end

  // Status byte
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      device_status <= `QRB_STATUS_RST;
    end else if (state == QRB_IDLE && release_i) begin
      device_status                <= 8'h00;
      device_status[`QRB_ST_DEVICE_READY_FLAG] <= 1'b1;
      device_status[`QRB_ST_SERVICE_PENDING] <= other_ready_i;
    end else if (state == QRB_RELEASED && cmd_prepared_i) begin
      device_status[`QRB_ST_SERVICE_PENDING] <= 1'b1;
    end else if (state != QRB_IDLE && other_ready_i) begin
      device_status[`QRB_ST_SERVICE_PENDING] <= 1'b1;
    end else if (state == QRB_SERVICING && !other_ready_i) begin
      device_status[`QRB_ST_SERVICE_PENDING] <= 1'b0;
    end
  end

  // Sticky events; hardware set wins so a clear never hides a fresh event
  for (genvar g = 0; g < `QRB_EVT_COUNT; g++) begin : gen_event
    logic hit;
    logic clr;
    assign hit = (g == `QRB_EVT_RELEASE && state == QRB_IDLE && release_i) ||
                 (g == `QRB_EVT_SERVICE && state == QRB_RELEASED && cmd_prepared_i) ||
                 (g == `QRB_EVT_SRVCMD && state == QRB_SERVICE_READY && service_cmd_i);
    assign clr = wr_fire && w_lane0 && aw_off == `QRB_OFF_EVENT && w_byte[g];
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        events[g] <= 1'b0;
      end else if (hit) begin
        events[g] <= 1'b1;
      end else if (clr) begin
        events[g] <= 1'b0;
      end
    end
  end : gen_event

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      service_pending_o <= 1'b0;
      service_taken_o   <= 1'b0;
    end else begin
      service_pending_o <= device_status[`QRB_ST_SERVICE_PENDING];
      // pulse hands over to transfer logic
      service_taken_o   <= (state == QRB_SERVICE_READY) && service_cmd_i;
    end
  end

  always_comb begin
    rd_hit  = reg_mapped(s_axi_araddr[7:0]);
    rd_byte = 8'h00;
    case (s_axi_araddr[7:0])
      `QRB_OFF_ERROR:    rd_byte = error_flags;
      `QRB_OFF_COUNT:    rd_byte = high_order_select ? count_tag.prev : count_tag.cur;
      `QRB_OFF_ADDR_LO:  rd_byte = high_order_select ? addr_low.prev : addr_low.cur;
      `QRB_OFF_ADDR_MID: rd_byte = high_order_select ? addr_mid.prev : addr_mid.cur;
      `QRB_OFF_ADDR_HI:  rd_byte = high_order_select ? addr_high.prev : addr_high.cur;
      `QRB_OFF_DEVSEL:   rd_byte = device_select;
      `QRB_OFF_STATUS:   rd_byte = device_status;
      `QRB_OFF_CONTROL:  rd_byte = control;
      `QRB_OFF_EVENT:    rd_byte = {{(8 - `QRB_EVT_COUNT){1'b0}}, events};
      `QRB_OFF_FEATURES: rd_byte = high_order_select ? features.prev : features.cur;
      `QRB_OFF_SECT_FULL: rd_byte[`QRB_SECT_FULL_BIT] = sector_full;
      default:           rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `QRB_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= rd_hit ? `QRB_RESP_OKAY : `QRB_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : qrb_release_regs

// [verilog/qrb_regs.svh]
`ifndef QRB_REGS_SVH
`define QRB_REGS_SVH
// Byte offsets on the AXI4-Lite register window
`define QRB_OFF_ERROR      8'h00
`define QRB_OFF_COUNT      8'h04
`define QRB_OFF_ADDR_LO    8'h08
`define QRB_OFF_ADDR_MID   8'h0C
`define QRB_OFF_ADDR_HI    8'h10
`define QRB_OFF_DEVSEL     8'h14
`define QRB_OFF_STATUS     8'h18
`define QRB_OFF_CONTROL    8'h1C
`define QRB_OFF_EVENT      8'h20
`define QRB_OFF_FEATURES   8'h24
`define QRB_OFF_SECT_FULL  8'h28
// Field positions
`define QRB_CNT_CD         0
`define QRB_CNT_IO         1
`define QRB_CNT_REL        2
`define QRB_DEV_BIT        4
`define QRB_ST_ERR         0
`define QRB_ST_DRQ         3
`define QRB_ST_SERVICE_PENDING        4
`define QRB_ST_DF          5
`define QRB_ST_DEVICE_READY_FLAG        6
`define QRB_ST_BSY         7
`define QRB_CTL_HOB        7
`define QRB_CTL_QUEUE      0
`define QRB_CTL_OVL        1
`define QRB_CTL_DEV        2
`define QRB_EVT_RELEASE    0
`define QRB_EVT_SERVICE    1
`define QRB_EVT_SRVCMD     2
`define QRB_EVT_COUNT      3
`define QRB_SECT_FULL_BIT  0
// Reset values and AXI response codes
`define QRB_STATUS_RST     8'h80
`define QRB_DEVSEL_RST     8'hA0
`define QRB_CTL_RST        8'h03
`define QRB_RESP_OKAY      2'b00
`define QRB_RESP_SLVERR    2'b10
`endif

// [verilog/qrb_pkg.sv]
package qrb_pkg;
  typedef enum logic [1:0] {
    QRB_IDLE,
    QRB_RELEASED,
    QRB_SERVICE_READY,
    QRB_SERVICING
  } qrb_state_t;

  typedef struct packed {
    logic [7:0] cur;
    logic [7:0] prev;
  } qrb_pair_t;
endpackage : qrb_pkg

// [bench/qrb_release_checker.sv]
module qrb_release_checker (
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic        release_i,
  input wire logic        other_ready_i,
  input wire logic        cmd_prepared_i,
  input wire logic        service_cmd_i,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        service_pending_o,
  input wire logic        service_taken_o
);
  logic idle;
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Shadow of the idle state; a release outside idle is ignored
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) idle <= 1'b1;
    else if (service_taken_o) idle <= 1'b1;
    else if (release_i) idle <= 1'b0;
  end
  chk_service_pending_release: assert property (release_i && idle |=> ##1
    service_pending_o == $past(other_ready_i, 2)) else $error("pending wrong after release");
  chk_service_pending_prepared: assert property (cmd_prepared_i && !idle |=> ##1
    service_pending_o) else $error("pending not set when prepared");
  chk_taken_cause: assert property (service_taken_o |->
    $past(service_cmd_i) && !idle) else $error("service taken without command");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_ar_answer: assert property (s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
  chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
  chk_b_answer: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid after handshake");
  chk_r_answer: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid after handshake");
endmodule : qrb_release_checker

bind qrb_release_regs qrb_release_checker qrb_release_checker_i (.*);

// [bench/qrb_host_model.sv]
module qrb_host_model (
  input  wire logic        clk_i,
  output logic [31:0]      awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [31:0]      wdata_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  output logic [31:0]      araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {awaddr_o, wdata_o, araddr_o, awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = '0;
  // host access
  // Response 11 marks a wait that ran out
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    r = 2'b11;
    @(posedge clk_i);
    awaddr_o <= {24'h0, a};
    wdata_o <= {24'h0, d};
    {awvalid_o, wvalid_o, bready_o} <= 3'b111;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (awvalid_o && awready_i) awvalid_o <= 1'b0;
      if (wvalid_o && wready_i) wvalid_o <= 1'b0;
      if (bvalid_i) begin
        bready_o <= 1'b0;
        r = bresp_i;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    r = 2'b11;
    d = '0;
    @(posedge clk_i);
    araddr_o <= {24'h0, a};
    {arvalid_o, rready_o} <= 2'b11;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (arvalid_o && arready_i) arvalid_o <= 1'b0;
      if (rvalid_i) begin
        rready_o <= 1'b0;
        {d, r} = {rdata_i, rresp_i};
        break;
      end
    end
  endtask : rd
endmodule : qrb_host_model

// [bench/testbench.sv]
`include "qrb_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 0, rst_n = 0, release_flag = 0, oth = 0, prep = 0, scmd = 0;
  logic [4:0]  tag = '0;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [1:0]  bresp, rresp;
  logic        awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr, pend, taken;
  int          n_errors = 0, cmp_count = 0;
  qrb_release_regs qrb_release_regs_i (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .release_i(release_flag),
    .release_tag_i(tag), .other_ready_i(oth), .cmd_prepared_i(prep), .service_cmd_i(scmd),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .service_pending_o(pend), .service_taken_o(taken));
  qrb_host_model qrb_host_model_i (.clk_i(sys_clk), .awaddr_o(awaddr), .awvalid_o(awv),
    .awready_i(awr), .wdata_o(wdata), .wvalid_o(wv), .wready_i(wr_r), .bresp_i(bresp),
    .bvalid_i(bv), .bready_o(br), .araddr_o(araddr), .arvalid_o(arv), .arready_i(arr),
    .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rv), .rready_o(rr));
  initial forever #10 sys_clk = ~sys_clk;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d, logic [1:0] er);
    logic [1:0] r;
    qrb_host_model_i.wr(a, d, r);
    chk("bresp", r, er);
    if (r === 2'b11) complete_run();
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e, logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    qrb_host_model_i.rd(a, d, r);
    chk("rdata", d, e);
    chk("rresp", r, er);
    if (r === 2'b11) complete_run();
  endtask : rd
  task automatic t_reset();
    rd(`QRB_OFF_STATUS, `QRB_STATUS_RST, `QRB_RESP_OKAY);
    rd(`QRB_OFF_DEVSEL, `QRB_DEVSEL_RST, `QRB_RESP_OKAY);
    rd(`QRB_OFF_CONTROL, `QRB_CTL_RST, `QRB_RESP_OKAY);
    rd(8'h40, 8'h00, `QRB_RESP_SLVERR);
    wr(8'h40, 8'h5A, `QRB_RESP_SLVERR);
    $display("test reset done");
  endtask : t_reset
  task automatic t_release(logic [4:0] t, logic [7:0] ctl, logic o);
    logic [7:0] cnt;
    cnt = {((ctl[1:0] == 2'b11) ? t : 5'h00), 3'b110};
    wr(`QRB_OFF_CONTROL, ctl, `QRB_RESP_OKAY);
    tag <= t;
    oth <= o;
    release_flag <= 1'b1;
    @(posedge sys_clk);
    release_flag <= 1'b0;
    rd(`QRB_OFF_COUNT, cnt, `QRB_RESP_OKAY);
    rd(`QRB_OFF_STATUS, {3'b010, o, 4'h0}, `QRB_RESP_OKAY);
    chk("pending", pend, o);
    prep <= 1'b1;
    @(posedge sys_clk);
    prep <= 1'b0;
    rd(`QRB_OFF_STATUS, 8'h50, `QRB_RESP_OKAY);
    rd(`QRB_OFF_COUNT, cnt, `QRB_RESP_OKAY);
    scmd <= 1'b1;
    @(posedge sys_clk);
    scmd <= 1'b0;
    @(posedge sys_clk);
    chk("taken", taken, 1'b1);
    @(posedge sys_clk);
    chk("taken", taken, 1'b0);
    oth <= 1'b0;
    $display("test release tag %0d done", t);
  endtask : t_release
  task automatic t_pair_dev();
    wr(`QRB_OFF_ADDR_LO, 8'h11, `QRB_RESP_OKAY);
    wr(`QRB_OFF_ADDR_LO, 8'h22, `QRB_RESP_OKAY);
    wr(`QRB_OFF_CONTROL, 8'h87, `QRB_RESP_OKAY);
    rd(`QRB_OFF_ADDR_LO, 8'h11, `QRB_RESP_OKAY);
    rd(`QRB_OFF_DEVSEL, 8'hB0, `QRB_RESP_OKAY);
    wr(`QRB_OFF_CONTROL, 8'h03, `QRB_RESP_OKAY);
    rd(`QRB_OFF_ADDR_LO, 8'h22, `QRB_RESP_OKAY);
    rd(`QRB_OFF_DEVSEL, 8'hA0, `QRB_RESP_OKAY);
    wr(`QRB_OFF_FEATURES, 8'h00, `QRB_RESP_OKAY);
    rd(`QRB_OFF_SECT_FULL, 8'h01, `QRB_RESP_OKAY);
    wr(`QRB_OFF_FEATURES, 8'h05, `QRB_RESP_OKAY);
    rd(`QRB_OFF_SECT_FULL, 8'h00, `QRB_RESP_OKAY);
    $display("test pair and device done");
  endtask : t_pair_dev
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_release(5'd0, 8'h03, 1'b0);
    t_release(5'd31, 8'h03, 1'b1);
    t_release(5'd21, 8'h01, 1'b0);
    t_release(5'd9, 8'h02, 1'b1);
    t_pair_dev();
    complete_run();
  end
endmodule : testbench
